/* src/cec_params.svh */
// Purpose: constants for the error confinement block
// Assumes: included by bare name
// Notes: byte addresses of the APB registers and counter limits
`ifndef CEC_PARAMS_SVH
`define CEC_PARAMS_SVH
`define CEC_ADDR_TXCNT   12'h000
`define CEC_ADDR_RXCNT   12'h004
`define CEC_ADDR_CTRL    12'h008
`define CEC_ADDR_STATUS  12'h00C
`define CEC_CNT_W        9
`define CEC_CNT_ZERO     9'h000
`define CEC_INC1         9'h001
`define CEC_INC8         9'h008
`define CEC_PASSIVE_LIM  9'h080
`define CEC_ACTIVE_MAX   9'h07F
`define CEC_BUSOFF_LIM   9'h100
`define CEC_CNT_MAX      9'h1FF
`define CEC_RX_RELOAD    9'h077
`define CEC_REC_DONE     9'h080
`define CEC_CTRL_SRST    0
`define CEC_CTRL_HOLD    1
`define CEC_CTRL_NAP     2
`define CEC_CTRL_PDN     3
`define CEC_ST_PASSIVE   0
`define CEC_ST_BUSOFF    1
`define CEC_ST_ACTIVE    2
`define CEC_ST_HOLD      3
`define CEC_BYTE_MASK    9'h0FF
`define CEC_DATA_ZERO    32'h0000_0000
`endif

/* src/cec_pkg.sv */
// Purpose: types for the error confinement block
// Assumes: none
// Notes: events arrive as one-cycle pulses
package cec_pkg;
   typedef enum logic [2:0] {
      CEC_ACTIVE  = 3'b001,
      CEC_PASSIVE = 3'b010,
      CEC_BUSOFF  = 3'b100
   } cec_state_e;

   typedef struct packed {
      logic rx_err;          // receiver error, not flag bit error
      logic rx_dom_after;    // dominant first bit after own flag
      logic tx_flag;         // transmitter sent error flag
      logic tx_ack_pass_ex;  // passive ack error exception
      logic tx_arb_stuff_ex; // arbitration stuff exception
      logic tx_flag_biterr;  // tx bit error in active/overload flag
      logic rx_flag_biterr;  // rx bit error in active/overload flag
      logic dom_seq;         // 14th/8th/each further 8 dominant bits
      logic tx_ok;           // frame transmitted successfully
      logic rx_ok;           // frame received successfully
      logic idle11;          // 11 consecutive recessive bits seen
   } cec_evt_s;
endpackage

/* src/cec_sat_add.sv */
// Purpose: saturating add or decrement on a counter value
// Assumes: none
// Notes: used for both counters
`timescale 1ns/1ps
`include "cec_params.svh"
module cec_sat_add
   import cec_pkg::*;
(
   input  wire logic [8:0] cnt_in,  // current count
   input  wire logic [8:0] add_val, // amount to add
   input  wire logic       dec,     // decrement by one
   output logic      [8:0] cnt_out  // result
);
   wire logic [9:0] sum;
   wire logic       dec_ok;

   assign sum     = {1'b0, cnt_in} + {1'b0, add_val};
   assign dec_ok  = dec && (cnt_in != `CEC_CNT_ZERO);
   // saturate high so bus-off stays detectable
   assign cnt_out = sum[9] ? `CEC_CNT_MAX :
                    dec_ok ? (sum[8:0] - `CEC_INC1) : sum[8:0];
endmodule // cec_sat_add

/* src/cec_core.sv */
// Purpose: CAN error counters, fault state and bus-off recovery
// Assumes: event inputs are one-cycle pulses synchronous to pclk
// Notes: APB slave, zero wait states, unmapped reads return zero
`timescale 1ns/1ps
`include "cec_params.svh"
// Operation
// RULE1 - counters readable any time, reads change nothing
// RULE2 - writing tx counter loads same value into both counters
// RULE3 - reset or module soft reset clears both counters
// RULE4 - nap and power down leave both counters unchanged
// RULE5 - receiver error adds one, except flag bit errors
// RULE6 - dominant bit after own flag adds eight to rx count
// RULE7 - transmitter error flag adds eight to tx count
// RULE8 - passive ack and arbitration stuff exceptions leave tx count
// RULE9 - tx bit error in active or overload flag adds eight
// RULE10 - rx bit error in active or overload flag adds eight
// RULE11 - long dominant sequences add eight to both counters
// RULE12 - good transmission decrements tx count, floor zero
// RULE13 - good reception decrements rx count in 1..127
// RULE14 - good reception above 127 sets rx count to 119..127
// RULE15 - error active while both counts below 128
// RULE16 - error passive at 128, active again at or below 127
// RULE17 - bus off when tx count reaches 256
// RULE18 - rx count not increased past passive limit
// RULE19 - bus off clears rx count, which then counts idle runs
// RULE20 - 128 idle runs return bus on, set hold, clear counters
// RULE21 - recovery touches only counters and status indications
// RULE22 - soft reset also sets init hold and clears counters
// RULE23 - tx counter nine bits wide, saturating, detects 256
module cec_core
   import cec_pkg::*;
(
   input  wire logic        pclk,       // clock
   input  wire logic        presetn,    // async reset, active low
   input  wire logic        psel,       // apb select
   input  wire logic        penable,    // apb enable
   input  wire logic        pwrite,     // apb direction
   input  wire logic [11:0] paddr,      // apb byte address
   input  wire logic [31:0] pwdata,     // apb write data
   output logic      [31:0] prdata,     // apb read data
   output logic             pready,     // apb ready
   output logic             pslverr,    // apb error
   input  wire cec_evt_s    evt,        // protocol events
   output logic             err_active, // error active state
   output logic             err_passive,// error passive state
   output logic             bus_off,    // bus off state
   output logic             send_err_frame, // active flags allowed
   output logic             init_hold   // hold bit, stops bus activity
);
   logic [8:0]   tx_cnt_reg, tx_cnt_next;
   logic [8:0]   rx_cnt_reg, rx_cnt_next;
   cec_state_e   state_reg, state_next;
   logic         hold_reg, hold_next;
   logic         nap_reg, pdn_reg;
   logic [31:0]  prdata_reg;

   wire logic       wr_en, rd_en;
   wire logic       wr_tx, wr_ctrl;
   wire logic       soft_rst;
   wire logic [8:0] tx_add, rx_add;
   wire logic [8:0] tx_sum, rx_sum;
   wire logic       tx_inc8, rx_inc1, rx_inc8;
   wire logic       rx_capped;
   wire logic [31:0] rd_mux;
   wire logic       recov_done;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;
   assign wr_tx   = wr_en && hit(paddr, `CEC_ADDR_TXCNT);  // RULE2
   assign wr_ctrl = wr_en && hit(paddr, `CEC_ADDR_CTRL);
   assign soft_rst = wr_ctrl && pwdata[`CEC_CTRL_SRST];   // RULE22
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // exceptions suppress the flag increment
   assign tx_inc8 = (evt.tx_flag && !evt.tx_ack_pass_ex
                     && !evt.tx_arb_stuff_ex)               // RULE7 RULE8
                    || evt.tx_flag_biterr                   // RULE9
                    || evt.dom_seq;                         // RULE11
   assign rx_inc1 = evt.rx_err;                             // RULE5
   assign rx_inc8 = evt.rx_dom_after                        // RULE6
                    || evt.rx_flag_biterr                   // RULE10
                    || evt.dom_seq;                         // RULE11
   assign rx_capped = (rx_cnt_reg >= `CEC_PASSIVE_LIM);     // RULE18
   assign tx_add = tx_inc8 ? `CEC_INC8 : `CEC_CNT_ZERO;
   assign rx_add = rx_capped ? `CEC_CNT_ZERO :
                   rx_inc8 ? `CEC_INC8 :
                   rx_inc1 ? `CEC_INC1 : `CEC_CNT_ZERO;

   cec_sat_add u_tx_add (
      .cnt_in  (tx_cnt_reg),
      .add_val (tx_add),
      .dec     (evt.tx_ok && !tx_inc8),                     // RULE12
      .cnt_out (tx_sum)
   );

   cec_sat_add u_rx_add (
      .cnt_in  (rx_cnt_reg),
      .add_val (rx_add),
      .dec     (evt.rx_ok && (rx_add == `CEC_CNT_ZERO)),   // RULE13
      .cnt_out (rx_sum)
   );

   assign recov_done = (state_reg == CEC_BUSOFF) && evt.idle11 &&
                       (rx_cnt_reg + `CEC_INC1 >= `CEC_REC_DONE);

   always_comb
   begin
      tx_cnt_next = tx_cnt_reg;
      rx_cnt_next = rx_cnt_reg;
      state_next  = state_reg;
      hold_next   = hold_reg;
      if (wr_ctrl)
         hold_next = pwdata[`CEC_CTRL_HOLD] || soft_rst;   // RULE22
      if (soft_rst)
      begin
         tx_cnt_next = `CEC_CNT_ZERO;                       // RULE3
         rx_cnt_next = `CEC_CNT_ZERO;
         state_next  = CEC_ACTIVE;
      end
      else if (wr_tx)
      begin
         tx_cnt_next = pwdata[8:0] & `CEC_BYTE_MASK;        // RULE2
         rx_cnt_next = pwdata[8:0] & `CEC_BYTE_MASK;
      end
      else
      begin
         unique case (state_reg)
            CEC_BUSOFF:
            begin
               if (recov_done)
               begin
                  tx_cnt_next = `CEC_CNT_ZERO;              // RULE20
                  rx_cnt_next = `CEC_CNT_ZERO;
                  state_next  = CEC_ACTIVE;
                  hold_next   = 1'b1;                       // RULE20
               end
               else if (evt.idle11)
                  rx_cnt_next = rx_cnt_reg + `CEC_INC1;     // RULE19
            end
            CEC_ACTIVE,
            CEC_PASSIVE:
            begin
               // counting is frozen while software holds the module
               if (!hold_reg)
               begin
                  tx_cnt_next = tx_sum;                     // RULE23
                  rx_cnt_next = rx_sum;
                  if (evt.rx_ok && rx_capped)
                     rx_cnt_next = `CEC_RX_RELOAD;          // RULE14
                  if (tx_sum >= `CEC_BUSOFF_LIM)
                  begin
                     state_next  = CEC_BUSOFF;              // RULE17
                     rx_cnt_next = `CEC_CNT_ZERO;           // RULE19
                  end
               end
            end
            default:
               // an illegal code falls back to the count-derived state
               state_next = CEC_ACTIVE;
         endcase
      end
      // fault state follows counts outside bus off
      if (state_next != CEC_BUSOFF)
      begin
         if (tx_cnt_next >= `CEC_PASSIVE_LIM ||
             rx_cnt_next >= `CEC_PASSIVE_LIM)
            state_next = CEC_PASSIVE;                       // RULE16
         else
            state_next = CEC_ACTIVE;                        // RULE15
      end
      if (wr_tx && tx_cnt_next >= `CEC_BUSOFF_LIM)
         state_next = CEC_BUSOFF;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_cnt_reg <= `CEC_CNT_ZERO;                       // RULE3
         rx_cnt_reg <= `CEC_CNT_ZERO;
         state_reg  <= CEC_ACTIVE;
         hold_reg   <= 1'b1;
      end
      else
      begin
         // nap and power down bits are not inputs here, so counts keep
         tx_cnt_reg <= tx_cnt_next;                         // RULE4
         rx_cnt_reg <= rx_cnt_next;
         state_reg  <= state_next;
         hold_reg   <= hold_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nap_reg <= 1'b0;
         pdn_reg <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         nap_reg <= pwdata[`CEC_CTRL_NAP];
         pdn_reg <= pwdata[`CEC_CTRL_PDN];
      end
   end

   // reads are side-effect free
   assign rd_mux =
      hit(paddr, `CEC_ADDR_TXCNT) ? {23'h0, tx_cnt_reg} :   // RULE1
      hit(paddr, `CEC_ADDR_RXCNT) ? {23'h0, rx_cnt_reg} :   // RULE1
      hit(paddr, `CEC_ADDR_CTRL)  ? {28'h0, pdn_reg, nap_reg,
                                     hold_reg, 1'b0} :
      hit(paddr, `CEC_ADDR_STATUS) ? {28'h0, hold_reg,
                                      state_reg == CEC_ACTIVE,
                                      state_reg == CEC_BUSOFF,
                                      state_reg == CEC_PASSIVE} :
      `CEC_DATA_ZERO;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= `CEC_DATA_ZERO;
      else if (rd_en)
         prdata_reg <= rd_mux;
   end

   assign prdata         = prdata_reg;
   assign err_active     = (state_reg == CEC_ACTIVE);       // RULE15
   assign err_passive    = (state_reg == CEC_PASSIVE);      // RULE16
   assign bus_off        = (state_reg == CEC_BUSOFF);       // RULE21
   assign send_err_frame = (state_reg == CEC_ACTIVE);
   assign init_hold      = hold_reg;
endmodule // cec_core

/* verif/cec_can_node.sv */
// Purpose: far-side CAN node model raising protocol events
// Assumes: go and req are set by the bench just after a rising edge
// Notes: every event reaches the core as a one-cycle pulse
`timescale 1ns/1ps
module cec_can_node
   import cec_pkg::*;
(
   input  wire logic     pclk,    // clock
   input  wire logic     presetn, // async reset, active low
   input  wire logic     go,      // raise req next cycle
   input  wire cec_evt_s req,     // events to raise
   output cec_evt_s      evt      // event pulses to core
);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         evt <= '0;
      else
         evt <= go ? req : '0;
endmodule // cec_can_node

/* verif/cec_core_asserts.sv */
// Purpose: port-level checks of the error confinement core
// Assumes: bound to cec_core
// Notes: counters are only seen through the fault state outputs
`timescale 1ns/1ps
module cec_core_asserts
   import cec_pkg::*;
(
   input wire logic        pclk,           // clock
   input wire logic        presetn,        // async reset, active low
   input wire logic        psel,           // apb select
   input wire logic        penable,        // apb enable
   input wire logic        pwrite,         // apb direction
   input wire logic [11:0] paddr,          // apb address
   input wire logic [31:0] pwdata,         // apb write data
   input wire logic [31:0] prdata,         // apb read data
   input wire logic        pready,         // apb ready
   input wire logic        pslverr,        // apb error
   input wire cec_evt_s    evt,            // protocol events
   input wire logic        err_active,     // error active
   input wire logic        err_passive,    // error passive
   input wire logic        bus_off,        // bus off
   input wire logic        send_err_frame, // error frames allowed
   input wire logic        init_hold       // hold bit
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // writes with an event in flight are left out: both would act at once
   wire wr_q   = psel && penable && pwrite && evt == '0;
   wire tx_wr  = wr_q && paddr == 12'h000 && !bus_off;
   wire ctl_wr = wr_q && paddr == 12'h008;
   state_onehot_a: assert property (
      $onehot({err_active, err_passive, bus_off}))
      else $error("fault state not one-hot");
   frame_en_a: assert property (
      send_err_frame == err_active) else $error("error frame enable wrong");
   tx_low_a: assert property (
      tx_wr && !pwdata[7] |=> err_active) else $error("low load not active");
   tx_high_a: assert property (
      tx_wr && pwdata[7] |=> err_passive) else $error("high load not passive");
   soft_rst_a: assert property (
      ctl_wr && pwdata[0] |=> init_hold && err_active)
      else $error("soft reset did not hold");
   recover_a: assert property (
      $fell(bus_off) |-> init_hold && err_active)
      else $error("bus-off exit without hold");
   read_calm_a: assert property (
      psel && !pwrite && evt == '0 && $past(evt) == '0
      |=> $stable({err_active, err_passive, bus_off}))
      else $error("read changed fault state");
   nap_calm_a: assert property (
      ctl_wr && !pwdata[0] && $past(evt) == '0
      |=> $stable({err_active, err_passive, bus_off}))
      else $error("low-power write changed state");
endmodule // cec_core_asserts

/* verif/can_error_confinement_tb.sv */
// Purpose: self-checking bench for the error confinement core
// Assumes: zero-wait APB slave, one-cycle event pulses
// Notes: bus-off recovery runs the full 128 idle runs
`timescale 1ns/1ps
`include "cec_params.svh"
module can_error_confinement_tb
   import cec_pkg::*;
;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        go = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, q;
   cec_evt_s    req = '0, evt;
   wire  [31:0] prdata;
   wire         pready, pslverr, err_active, err_passive, bus_off;
   wire         send_err_frame, init_hold;
   int          n_errors = 0, compares = 0;
   always #2.5 pclk = ~pclk;
   cec_core u_cec_core (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
      .err_active(err_active), .err_passive(err_passive), .bus_off(bus_off),
      .send_err_frame(send_err_frame), .init_hold(init_hold));
   cec_can_node u_cec_can_node (.pclk(pclk), .presetn(presetn), .go(go),
      .req(req), .evt(evt));
   task end_sim;
      if (n_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      chk("pslverr", 32'(pslverr), 32'h0);
      psel <= 0;
      penable <= 0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(0, a, 32'h0);
      chk(nm, q, e);
   endtask
   task ev(input cec_evt_s m, input int k);
      repeat (k)
      begin
         @(posedge pclk);
         go <= 1;
         req <= m;
         @(posedge pclk);
         go <= 0;
         @(posedge pclk);
      end
      // the core updates on the last edge above; let it settle first
      @(posedge pclk);
   endtask
   task t_rx;
      rd(`CEC_ADDR_TXCNT, 32'h0, "tx reset");
      rd(`CEC_ADDR_STATUS, 32'hC, "status reset");
      apb(1, `CEC_ADDR_CTRL, 32'h0);
      ev(11'h400, 3);
      ev(11'h010, 1);
      ev(11'h200, 1);
      ev(11'h002, 1);
      rd(`CEC_ADDR_RXCNT, 32'h12, "rx count");
      rd(`CEC_ADDR_RXCNT, 32'h12, "rx reread");
   endtask
   task t_tx;
      ev(11'h100, 1);
      ev(11'h180, 1);
      ev(11'h140, 1);
      rd(`CEC_ADDR_TXCNT, 32'h8, "tx flag");
      ev(11'h020, 1);
      ev(11'h008, 1);
      ev(11'h004, 1);
      rd(`CEC_ADDR_TXCNT, 32'h17, "tx count");
      rd(`CEC_ADDR_RXCNT, 32'h1A, "rx dominant");
   endtask
   task t_pass;
      apb(1, `CEC_ADDR_TXCNT, 32'h80);
      rd(`CEC_ADDR_RXCNT, 32'h80, "rx loaded");
      chk("passive", 32'(send_err_frame), 32'h0);
      ev(11'h400, 1);
      rd(`CEC_ADDR_RXCNT, 32'h80, "rx capped");
      ev(11'h002, 1);
      rd(`CEC_ADDR_RXCNT, 32'h77, "rx reload");
      chk("still passive", 32'(err_passive), 32'h1);
      ev(11'h004, 1);
      chk("active again", 32'(err_active), 32'h1);
   endtask
   task t_nap;
      apb(1, `CEC_ADDR_CTRL, 32'h4);
      apb(1, `CEC_ADDR_CTRL, 32'h8);
      apb(1, `CEC_ADDR_CTRL, 32'h0);
      rd(`CEC_ADDR_TXCNT, 32'h7F, "tx after nap");
      rd(`CEC_ADDR_RXCNT, 32'h77, "rx after nap");
   endtask
   task t_boff;
      apb(1, `CEC_ADDR_TXCNT, 32'hFF);
      ev(11'h100, 1);
      rd(`CEC_ADDR_STATUS, 32'h2, "bus off");
      rd(`CEC_ADDR_RXCNT, 32'h0, "rx cleared");
      ev(11'h001, 127);
      rd(`CEC_ADDR_RXCNT, 32'h7F, "idle runs");
      ev(11'h001, 1);
      rd(`CEC_ADDR_STATUS, 32'hC, "recovered");
      rd(`CEC_ADDR_TXCNT, 32'h0, "tx recovered");
   endtask
   task t_soft;
      apb(1, `CEC_ADDR_TXCNT, 32'h5);
      apb(1, `CEC_ADDR_CTRL, 32'h0);
      ev(11'h400, 1);
      rd(`CEC_ADDR_RXCNT, 32'h6, "rx before soft");
      apb(1, `CEC_ADDR_CTRL, 32'h1);
      rd(`CEC_ADDR_RXCNT, 32'h0, "rx soft");
      chk("hold set", 32'(init_hold), 32'h1);
      apb(1, `CEC_ADDR_CTRL, 32'h0);
      ev(11'h004, 1);
      rd(`CEC_ADDR_TXCNT, 32'h0, "tx floor");
      rd(12'h010, 32'h0, "unmapped");
   endtask
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      t_rx;
      t_tx;
      t_pass;
      t_nap;
      t_boff;
      t_soft;
      end_sim;
   end
   initial
   begin
      #50000;
      n_errors++;
      end_sim;
   end
endmodule // can_error_confinement_tb
bind cec_core cec_core_asserts u_cec_core_asserts (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .evt(evt), .err_active(err_active),
   .err_passive(err_passive), .bus_off(bus_off),
   .send_err_frame(send_err_frame), .init_hold(init_hold));
